// ===== inc/baud_pkg.sv
package baud_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] TRANSMIT_CONTROL_OFS  = 8'h00;
  localparam logic [7:0] RECEIVE_CONTROL_OFS   = 8'h04;
  localparam logic [7:0] BAUD_CONTROL_OFS      = 8'h08;
  localparam logic [7:0] DIVISOR_LOW_OFS       = 8'h0C;
  localparam logic [7:0] DIVISOR_HIGH_OFS      = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SYNC_MODE_BIT        = 4;  // transmit_control
  localparam int HIGH_SPEED_BIT       = 2;  // transmit_control
  localparam int SHIFT_EMPTY_BIT      = 1;  // transmit_control, read only
  localparam int RECEIVE_IDLE_BIT     = 6;  // baud_control, read only
  localparam int WIDE_DIVISOR_BIT     = 3;  // baud_control

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] TRANSMIT_CONTROL_RST  = 8'h02;
  localparam logic [7:0] RECEIVE_CONTROL_RST   = 8'h00;
  localparam logic [7:0] BAUD_CONTROL_RST      = 8'h40;
  localparam logic [7:0] DIVISOR_RST           = 8'h00;
  localparam logic [7:0] TRANSMIT_CONTROL_MASK = 8'hFD;
  localparam logic [7:0] RECEIVE_CONTROL_MASK  = 8'hF9;
  localparam logic [7:0] BAUD_CONTROL_MASK     = 8'h1B;

  // ----------------------------------------------------------------
  // divide factors applied to (n+1)
  // ----------------------------------------------------------------
  localparam logic [5:0] FACTOR_SLOW_NARROW    = 6'h3F;  // 64 - 1
  localparam logic [5:0] FACTOR_MID            = 6'h0F;  // 16 - 1
  localparam logic [5:0] FACTOR_FAST           = 6'h03;  // 4 - 1

  // mode bits that shape the timer period
  typedef struct packed {
    logic sync_mode;
    logic wide_divisor_select;
    logic high_speed_select;
  } rate_mode_type;

endpackage : baud_pkg

// ===== hdl/baud_timer_top.sv
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/10ps

// Operation
// R1: reset in 8-bit mode, 16-bit when wide set
// R2: free running, period from high:low divisor
// R3: async factor uses speed and width; sync ignores speed
// R4: divisor write clears timer at once
// R5: async narrow slow: divide by 64(n+1)
// R6: async wide slow: divide by 16(n+1)
// R7: sync: divide by 4(n+1)
// R8: async fast: 16 narrow, 4 wide
// R9: software checks receive idle before clock change
// R10: receive idle flag reads receiver idle state
// R11: mode bit one means synchronous operation
module baud_timer_top #(
  parameter int DIV_WIDTH = 16
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  // status from shift logic
  input  wire logic        RECEIVE_IDLE,
  input  wire logic        SHIFT_EMPTY,
  // to shift logic
  output logic             BAUD_TICK,
  output logic             SYNC_MODE
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]           transmit_control;
  logic [7:0]           receive_control;
  logic [7:0]           baud_control;
  logic [7:0]           divisor_low;
  logic [7:0]           divisor_high;
  logic                 receive_idle_flag;
  logic                 shift_empty;
  logic [5:0]           prescale;
  logic [DIV_WIDTH-1:0] baud_timer;

  logic                 access;
  logic                 wr_en;
  logic                 divisor_write;
  logic                 prescale_done;
  logic [5:0]           factor_last;
  logic [DIV_WIDTH-1:0] divisor;
  baud_pkg::rate_mode_type mode;

  // address decode, shared by read and write paths
  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = (addr == baud_pkg::TRANSMIT_CONTROL_OFS) ||
               (addr == baud_pkg::RECEIVE_CONTROL_OFS)  ||
               (addr == baud_pkg::BAUD_CONTROL_OFS)     ||
               (addr == baud_pkg::DIVISOR_LOW_OFS)      ||
               (addr == baud_pkg::DIVISOR_HIGH_OFS);
  endfunction : addr_hit

  // divide factor minus one for the selected mode
  function automatic logic [5:0] factor_of(input baud_pkg::rate_mode_type m);
    if (m.sync_mode) begin
      factor_of = baud_pkg::FACTOR_FAST;                         // R7 R3
    end else if (!m.wide_divisor_select) begin
      factor_of = m.high_speed_select ? baud_pkg::FACTOR_MID     // R8
                                      : baud_pkg::FACTOR_SLOW_NARROW; // R5
    end else begin
      factor_of = m.high_speed_select ? baud_pkg::FACTOR_FAST    // R8
                                      : baud_pkg::FACTOR_MID;    // R6
    end
  endfunction : factor_of

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // write lands on the single access cycle in which pready is high
  assign access        = PSEL && PENABLE && PREADY;
  assign wr_en         = access && PWRITE && addr_hit(PADDR);
  assign divisor_write = wr_en && ((PADDR == baud_pkg::DIVISOR_LOW_OFS) ||
                                   (PADDR == baud_pkg::DIVISOR_HIGH_OFS));

  // ----------------------------------------------------------------
  // rate selection
  // ----------------------------------------------------------------
  // mode bits act at once; only a divisor write restarts the count
  assign mode.sync_mode           = transmit_control[baud_pkg::SYNC_MODE_BIT];    // R11
  assign mode.wide_divisor_select = baud_control[baud_pkg::WIDE_DIVISOR_BIT];
  assign mode.high_speed_select   = transmit_control[baud_pkg::HIGH_SPEED_BIT];
  assign factor_last = factor_of(mode);

  // narrow mode leaves the high byte out of the divisor; a write to it still restarts the count
  assign divisor = mode.wide_divisor_select                      // R1
                 ? DIV_WIDTH'({divisor_high, divisor_low})       // R2
                 : DIV_WIDTH'(divisor_low);

  // ----------------------------------------------------------------
  // apb answer: one wait-free access cycle after setup
  // ----------------------------------------------------------------
  // ready is registered so the answer comes from flops; costs no cycle
  // unmapped offsets answer with an error, read as zero and ignore writes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !addr_hit(PADDR);
      PRDATA  <= 32'h0000_0000;
      if (PSEL && !PENABLE && !PWRITE) begin
        unique case (PADDR)
          baud_pkg::TRANSMIT_CONTROL_OFS: PRDATA <= {24'h000000, transmit_control[7:2],
                                                     shift_empty, transmit_control[0]};
          baud_pkg::RECEIVE_CONTROL_OFS:  PRDATA <= {24'h000000, receive_control};
          baud_pkg::BAUD_CONTROL_OFS:     PRDATA <= {24'h000000, baud_control[7],
                                                     receive_idle_flag, baud_control[5:0]}; // R10
          baud_pkg::DIVISOR_LOW_OFS:      PRDATA <= {24'h000000, divisor_low};
          baud_pkg::DIVISOR_HIGH_OFS:     PRDATA <= {24'h000000, divisor_high};
          default:                        PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // read-only bits are masked so software cannot overwrite them
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      transmit_control <= baud_pkg::TRANSMIT_CONTROL_RST;
      receive_control  <= baud_pkg::RECEIVE_CONTROL_RST;
      baud_control     <= baud_pkg::BAUD_CONTROL_RST;     // R1
    end else if (wr_en) begin
      if (PADDR == baud_pkg::TRANSMIT_CONTROL_OFS) begin
        transmit_control <= PWDATA[7:0] & baud_pkg::TRANSMIT_CONTROL_MASK;
      end
      if (PADDR == baud_pkg::RECEIVE_CONTROL_OFS) begin
        receive_control <= PWDATA[7:0] & baud_pkg::RECEIVE_CONTROL_MASK;
      end
      if (PADDR == baud_pkg::BAUD_CONTROL_OFS) begin
        baud_control <= PWDATA[7:0] & baud_pkg::BAUD_CONTROL_MASK;
      end
    end
  end

  // divisor pair
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      divisor_low  <= baud_pkg::DIVISOR_RST;
      divisor_high <= baud_pkg::DIVISOR_RST;
    end else if (wr_en) begin
      if (PADDR == baud_pkg::DIVISOR_LOW_OFS) begin
        divisor_low <= PWDATA[7:0];
      end
      if (PADDR == baud_pkg::DIVISOR_HIGH_OFS) begin
        divisor_high <= PWDATA[7:0];
      end
    end
  end

  // status sampled from the shift logic
  // limitation: software sees the idle flag two clocks after the receiver
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      receive_idle_flag <= 1'b1;
      shift_empty       <= 1'b1;
    end else begin
      receive_idle_flag <= RECEIVE_IDLE;                 // R10
      shift_empty       <= SHIFT_EMPTY;
    end
  end

  // ----------------------------------------------------------------
  // baud timer: prescaler times (n+1) counter
  // ----------------------------------------------------------------
  // prescaler gives a one-cycle enable that paces the (n+1) counter, so
  // the whole block stays on the single system clock
  // >= guards a factor shrinking mid-count from wrapping the long way
  assign prescale_done = (prescale >= factor_last);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prescale <= 6'h00;
    end else if (divisor_write || prescale_done) begin
      prescale <= 6'h00;                                  // R4
    end else begin
      prescale <= prescale + 6'h01;                       // R2
    end
  end

  // counter restarts on a divisor write so the new rate starts at once
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      baud_timer <= '0;
    end else if (divisor_write) begin
      baud_timer <= '0;                                   // R4
    end else if (prescale_done) begin
      baud_timer <= (baud_timer >= divisor) ? '0 : baud_timer + 1'b1;  // R2
    end
  end

  // one-cycle tick every factor*(n+1) clocks
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      BAUD_TICK <= 1'b0;
      SYNC_MODE <= 1'b0;
    end else begin
      BAUD_TICK <= !divisor_write && prescale_done && (baud_timer >= divisor); // R5 R6 R7 R8
      SYNC_MODE <= mode.sync_mode;                        // R11
    end
  end

endmodule : baud_timer_top

// ===== dv/baud_timer_props.sv
`timescale 1ns/10ps
// ------------------------------------------------
// port checker for the baud timer
// ------------------------------------------------
module baud_timer_props #(
  parameter int DIV_WIDTH = 16
) (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // apb side
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR,
  // shift logic side
  input wire logic        RECEIVE_IDLE,
  input wire logic        SHIFT_EMPTY,
  input wire logic        BAUD_TICK,
  input wire logic        SYNC_MODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // accepted access and decoded targets
  wire acc    = PSEL && PENABLE && PREADY;
  wire div_wr = acc && PWRITE && (PADDR == 8'h0C || PADDR == 8'h10);
  wire mapped = PADDR inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  // register updates at the access edge, the pin one edge after that
  property p_sync;
    acc && PWRITE && PADDR == 8'h00 |-> ##2 SYNC_MODE == $past(PWDATA[4], 2);
  endproperty
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY && PENABLE)
    else $error("ready missing after setup");
  a_ready_single: assert property (PREADY |=> !PREADY) else $error("ready held");
  a_slverr_map: assert property (PREADY |-> PSLVERR == !mapped) else $error("bad slverr");
  a_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper set");
  a_tick_single: assert property (BAUD_TICK |=> !BAUD_TICK) else $error("long tick");
  a_divisor_clear: assert property (div_wr |=> !BAUD_TICK [*3])
    else $error("tick soon after divisor write");
  a_sync_copy: assert property (p_sync) else $error("sync mode not copied");
  a_idle_read: assert property (acc && !PWRITE && PADDR == 8'h08 && $stable(RECEIVE_IDLE)
    && $past(RECEIVE_IDLE, 2) == RECEIVE_IDLE |-> PRDATA[6] == RECEIVE_IDLE)
    else $error("idle flag wrong");
  c_div_write: cover property (div_wr);
  c_sync_tick: cover property (BAUD_TICK && SYNC_MODE);
  c_unmapped: cover property (PREADY && PSLVERR);
endmodule : baud_timer_props
bind baud_timer_top baud_timer_props #(.DIV_WIDTH(DIV_WIDTH)) props_u (.CLK(CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .RECEIVE_IDLE(RECEIVE_IDLE),
  .SHIFT_EMPTY(SHIFT_EMPTY), .BAUD_TICK(BAUD_TICK), .SYNC_MODE(SYNC_MODE));

// ===== dv/shift_model.sv
`timescale 1ns/10ps
// ------------------------------------------------
// stand-in for the shift logic
// ------------------------------------------------
module shift_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pacing and frame start
  input wire logic tick,
  input wire logic start,
  // status back to the baud block
  output logic     rx_idle,
  output logic     tx_empty
);
  logic [3:0] left;
  // a frame lasts ten ticks, so a slow rate keeps it busy for long
  always_ff @(posedge clk or posedge rst) begin
    if (rst) left <= 4'h0;
    else if (start) left <= 4'hA;
    else if (tick && left != 4'h0) left <= left - 4'h1;
  end
  assign rx_idle  = (left == 4'h0);
  assign tx_empty = (left == 4'h0);
endmodule : shift_model

// ===== dv/test_serial_baud_rate_generator.sv
`timescale 1ns/10ps
`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("BAD %0t %h %h", $time, (g), (e)); \
  end \
end
// ------------------------------------------------
// register and tick period tests
// ------------------------------------------------
module test_serial_baud_rate_generator;
  logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, start = 0, err;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, RECEIVE_IDLE, SHIFT_EMPTY, BAUD_TICK, SYNC_MODE;
  int fails = 0, checked = 0, n;
  logic [7:0] addrs[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  logic [31:0] resets[5] = '{32'h2, 32'h0, 32'h40, 32'h0, 32'h0};
  logic [7:0] txm[7] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h10, 8'h14, 8'h14};
  logic [7:0] bdm[7] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00, 8'h08};
  int fac[7] = '{64, 16, 16, 4, 4, 4, 4};
  baud_timer_top dut_u (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .RECEIVE_IDLE(RECEIVE_IDLE), .SHIFT_EMPTY(SHIFT_EMPTY), .BAUD_TICK(BAUD_TICK),
    .SYNC_MODE(SYNC_MODE));
  shift_model far_u (.clk(CLK), .rst(RST), .tick(BAUD_TICK), .start(start),
    .rx_idle(RECEIVE_IDLE), .tx_empty(SHIFT_EMPTY));
  // free clock
  initial forever #5 CLK = ~CLK;
  task automatic stop_test();
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // one apb transfer; an idle edge first so strobes never toggle twice at one edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    i = 0;
    do begin
      @(posedge CLK);
      i++;
    end while (PREADY !== 1'b1 && i < 20);
    if (PREADY !== 1'b1) begin
      fails++;
      stop_test();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : xfer
  // cycles up to the next tick, looked at just after each edge
  task automatic gap(input int exp);
    int c;
    c = 0;
    do begin
      @(posedge CLK);
      #1;
      c++;
    end while (BAUD_TICK !== 1'b1 && c < 5000);
    `CHK(c, exp)
    if (c >= 5000) stop_test();
  endtask : gap
  // main sequence
  initial begin
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    gap(64);
    gap(64);
    foreach (addrs[i]) begin
      xfer(1'b0, addrs[i], 32'h0);
      `CHK(rd, resets[i])
    end
    xfer(1'b0, 8'h14, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    xfer(1'b1, 8'h08, 32'hFF);
    xfer(1'b0, 8'h08, 32'h0);
    `CHK(rd, 32'h5B)
    xfer(1'b1, 8'h04, 32'hFF);
    xfer(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'hF9)
    xfer(1'b1, 8'h00, 32'hFF);
    xfer(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'hFF)
    xfer(1'b1, 8'h10, 32'h1);
    xfer(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h1)
    for (int m = 0; m < 7; m++) begin
      xfer(1'b1, 8'h00, {24'h0, txm[m]});
      xfer(1'b1, 8'h08, {24'h0, bdm[m]});
      xfer(1'b1, 8'h0C, 32'h2);
      n = bdm[m][3] ? 259 : 3;
      gap(fac[m] * n);
      gap(fac[m] * n);
      `CHK(SYNC_MODE, txm[m][4])
    end
    xfer(1'b1, 8'h10, 32'h1);
    gap(1036);
    @(posedge CLK);
    start <= 1'b1;
    @(posedge CLK);
    start <= 1'b0;
    repeat (3) @(posedge CLK);
    xfer(1'b0, 8'h08, 32'h0);
    `CHK(rd[6], 1'b0)
    xfer(1'b0, 8'h00, 32'h0);
    `CHK(rd[1], 1'b0)
    // wait for an idle receiver before any clock change
    n = 0;
    do begin
      xfer(1'b0, 8'h08, 32'h0);
      n++;
    end while (rd[6] !== 1'b1 && n < 5000);
    `CHK(rd[6], 1'b1)
    stop_test();
  end
endmodule : test_serial_baud_rate_generator
